/* File: core/blx_pkg.sv */
// Purpose: shared constants, types and decode helpers for the branch-likely exception control block
// Assumes: 32-bit instruction words, 4 KiB pages, byte-addressed register port
// Notes:   opcode fields follow the usual 32-bit RISC encoding
package blx_pkg;
	localparam logic [7:0]  REG_RET_PC   = 8'h00;
	localparam logic [7:0]  REG_CAUSE    = 8'h04;
	localparam logic [7:0]  REG_DPC      = 8'h08;
	localparam logic [7:0]  REG_DEBUG    = 8'h0C;
	localparam logic [7:0]  REG_EVT      = 8'h10;
	localparam logic [7:0]  REG_MASK     = 8'h14;
	localparam logic [7:0]  REG_CTRL     = 8'h18;
	localparam logic [7:0]  REG_ID       = 8'h1C;
	localparam int          FLAG_BIT     = 31;
	localparam int          CODE_LO      = 2;
	localparam int          CODE_W       = 5;
	localparam logic [4:0]  EXC_INT      = 5'h00;
	localparam logic [4:0]  EXC_BUS      = 5'h06;
	localparam logic [4:0]  EXC_NMI      = 5'h10;
	localparam int          EVT_INT      = 0;
	localparam int          EVT_DBG      = 1;
	localparam int          EVT_NMI      = 2;
	localparam int          EVT_BUS      = 3;
	localparam int          EVT_W        = 4;
	localparam int          CTRL_XLATE   = 0;
	localparam int          PAGE_W       = 12;
	localparam int          VPN_W        = 20;
	localparam logic [31:0] PC_STEP      = 32'h0000_0004;
	localparam logic [31:0] WORD_RST     = 32'h0000_0000;
	localparam logic [5:0]  OP_SPECIAL   = 6'h00;
	localparam logic [5:0]  OP_REGIMM    = 6'h01;
	localparam logic [4:0]  OP_JUMP_HI   = 5'h01;
	localparam logic [3:0]  OP_BRANCH_HI = 4'h1;
	localparam logic [3:0]  OP_LIKELY_HI = 4'h5;
	localparam logic [3:0]  OP_COPZ_HI   = 4'h4;
	localparam logic [4:0]  RS_BC        = 5'h08;
	localparam logic [2:0]  RT_PLAIN     = 3'h0;
	localparam logic [2:0]  RT_LIKELY    = 3'h1;
	localparam logic [3:0]  RT_BC_PLAIN  = 4'h0;
	localparam logic [3:0]  RT_BC_LIKELY = 4'h1;
	localparam logic [4:0]  FN_JR_HI     = 5'h04;

	typedef enum {X_IDLE, X_WALK} xlate_state_type;

	function automatic logic is_likely(input logic [31:0] w);
		is_likely = (w[31:28] == OP_LIKELY_HI) ||
			((w[31:26] == OP_REGIMM) && (w[19:17] == RT_LIKELY)) ||
			((w[31:28] == OP_COPZ_HI) && (w[25:21] == RS_BC) && (w[20:17] == RT_BC_LIKELY));
	endfunction

	function automatic logic is_plain_branch(input logic [31:0] w);
		is_plain_branch = (w[31:28] == OP_BRANCH_HI) || (w[31:27] == OP_JUMP_HI) ||
			((w[31:26] == OP_REGIMM) && (w[19:17] == RT_PLAIN)) ||
			((w[31:26] == OP_SPECIAL) && (w[5:1] == FN_JR_HI)) ||
			((w[31:28] == OP_COPZ_HI) && (w[25:21] == RS_BC) && (w[20:17] == RT_BC_PLAIN));
	endfunction
endpackage

/* File: core/xlate_if.sv */
// Purpose: fetch address translation request and answer between core logic and buffer
// Assumes: requester holds req until done
// Notes:   done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface xlate_if;
	logic        req;
	logic [31:0] vaddr;
	logic        on;
	logic        done;
	logic [31:0] paddr;
	modport core (output req, output vaddr, output on, input done, input paddr);
	modport tlb  (input req, input vaddr, input on, output done, output paddr);
endinterface
`default_nettype wire

/* File: core/branch_decode.sv */
// Purpose: classify an issued word as delay-slot branch and as branch-likely
// Assumes: word stable while issue_valid is high
// Notes:   purely combinational; the clock only serves the checks
`timescale 1ns/1ps
`default_nettype none
module branch_decode
	import blx_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [31:0] instr,
	output logic             likely,
	output logic             has_slot
);
	assign likely   = is_likely(instr);
	assign has_slot = likely || is_plain_branch(instr);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	AST_GROUP_OPCODE: assert property ((instr[31:28] == OP_LIKELY_HI) |-> likely && has_slot)
		else $error("compare-likely opcode not classed likely");
	AST_GROUP_REGIMM: assert property ((instr[31:26] == OP_REGIMM && instr[19:17] == RT_LIKELY) |-> likely)
		else $error("zero-compare likely not classed likely");
	AST_GROUP_COPZ: assert property ((instr[31:28] == OP_COPZ_HI && instr[25:21] == RS_BC
		&& instr[20:17] == RT_BC_LIKELY) |-> likely)
		else $error("coprocessor likely not classed likely");
endmodule // branch_decode
`default_nettype wire

/* File: core/fetch_translation_buffer.sv */
// Purpose: small fetch translation buffer refilled by hardware from the main table
// Assumes: main table answers walk_req with a one-cycle walk_ack and walk_pfn
// Notes:   round-robin victim; no flush port, software must not remap live pages
`timescale 1ns/1ps
`default_nettype none
module fetch_translation_buffer
	import blx_pkg::*;
#(
	parameter int ENTRIES = 2
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	xlate_if.tlb                  xif,
	output logic                  walk_req,
	output logic [VPN_W-1:0]      walk_vpn,
	input  wire logic             walk_ack,
	input  wire logic [VPN_W-1:0] walk_pfn
);
	localparam int IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

	xlate_state_type  st_q;
	logic [VPN_W-1:0] vpn_q [ENTRIES];
	logic [VPN_W-1:0] pfn_q [ENTRIES];
	logic [ENTRIES-1:0] valid_q;
	logic [IDX_W-1:0] victim_q;
	logic             walk_q;
	logic [VPN_W-1:0] wvpn_q;
	logic             done_q;
	logic [31:0]      paddr_q;
	logic             hit;
	logic [VPN_W-1:0] hit_pfn;
	logic [VPN_W-1:0] vpn;

	assign vpn      = xif.vaddr[31:PAGE_W];
	assign walk_req = walk_q;
	assign walk_vpn = wvpn_q;
	assign xif.done = done_q;
	assign xif.paddr = paddr_q;

	always_comb begin
		hit     = 1'b0;
		hit_pfn = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			if (valid_q[i] && (vpn_q[i] == vpn)) begin
				hit     = 1'b1;
				hit_pfn = pfn_q[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q     <= X_IDLE;
			valid_q  <= '0;
			victim_q <= '0;
			walk_q   <= 1'b0;
			wvpn_q   <= '0;
			done_q   <= 1'b0;
			paddr_q  <= WORD_RST;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				X_IDLE: begin
					if (xif.req && !done_q) begin
						if (!xif.on || hit) begin
							done_q  <= 1'b1;
							paddr_q <= xif.on ? {hit_pfn, xif.vaddr[PAGE_W-1:0]} : xif.vaddr;
						end else begin
							walk_q <= 1'b1;
							wvpn_q <= vpn;
							st_q   <= X_WALK;
						end
					end
				end
				X_WALK: begin
					if (walk_ack) begin
						walk_q           <= 1'b0;
						vpn_q[victim_q]  <= wvpn_q;
						pfn_q[victim_q]  <= walk_pfn;
						valid_q[victim_q] <= 1'b1;
						victim_q <= (victim_q == IDX_W'(ENTRIES - 1)) ? '0 : victim_q + 1'b1;
						st_q     <= X_IDLE;
					end
				end
				default: st_q <= X_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	AST_MISS_WALKS: assert property ((st_q == X_IDLE && xif.req && !done_q && xif.on && !hit)
		|=> walk_req && walk_vpn == $past(vpn))
		else $error("miss did not start a refill");
	AST_REFILL_SERVES: assert property ((st_q == X_WALK && walk_ack && xif.req) ##1 xif.req
		|-> ##1 (xif.done && xif.paddr[31:PAGE_W] == $past(walk_pfn, 2)))
		else $error("refilled page not served two cycles after ack");
	COV_REFILL: cover property (walk_req ##1 walk_ack ##[1:3] xif.done);
endmodule // fetch_translation_buffer
`default_nettype wire

/* File: core/branch_likely_exception_ctl.sv */
// Purpose: exception entry and delay-slot recording for branch-likely instructions
// Assumes: issue stream, interrupt requests and main table on clk_sys; delay slot issues right after its branch
// Notes:   exc_take and the saved registers update one cycle after the taken request
`timescale 1ns/1ps
`default_nettype none
module branch_likely_exception_ctl
	import blx_pkg::*;
#(
	parameter logic [31:0] ID_VALUE = 32'h0000_0A5A, // arbitrary identity value
	parameter int          XLATE_ENTRIES = 2
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic             issue_valid,
	input  wire logic [31:0]      issue_pc,
	input  wire logic [31:0]      issue_instr,
	input  wire logic             issue_cond_true,
	input  wire logic             irq_req,
	input  wire logic             debug_interrupt_exc,
	input  wire logic             nmi_req,
	input  wire logic             bus_fault_exc,
	input  wire logic             fetch_req,
	input  wire logic [31:0]      fetch_vaddr,
	output logic                  fetch_done,
	output logic [31:0]           fetch_paddr,
	output logic                  walk_req,
	output logic [VPN_W-1:0]      walk_vpn,
	input  wire logic             walk_ack,
	input  wire logic [VPN_W-1:0] walk_pfn,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [31:0]           reg_rdata,
	output logic                  slot_cancel,
	output logic                  exc_take,
	output logic                  exc_debug,
	output logic                  core_halt,
	output logic                  irq_out
);
	logic              dec_likely;
	logic              dec_has_slot;
	logic              slot_next_q;
	logic              cancel_q;
	logic [31:0]       last_pc_q;
	logic [31:0]       exception_return_pc_q;
	logic              delay_slot_flag_q;
	logic [CODE_W-1:0] cause_code_q;
	logic [31:0]       debug_return_pc_q;
	logic              debug_delay_slot_flag_q;
	logic [EVT_W-1:0]  evt_q;
	logic [EVT_W-1:0]  evt_d;
	logic [EVT_W-1:0]  evt_set;
	logic [EVT_W-1:0]  evt_clr;
	logic [EVT_W-1:0]  mask_q;
	logic [31:0]       ctrl_q;
	logic [31:0]       rdata_q;
	logic              take_q;
	logic              debug_q;
	logic              halt_q;
	logic              irq_q;
	logic              take_bus;
	logic              take_nmi;
	logic              take_dbg;
	logic              take_irq;
	logic              any_take;
	logic              in_slot;
	logic [31:0]       ret_pc;

	xlate_if xif ();

	branch_decode u_decode (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.instr    (issue_instr),
		.likely   (dec_likely),
		.has_slot (dec_has_slot)
	);

	fetch_translation_buffer #(
		.ENTRIES (XLATE_ENTRIES)
	) u_fetch_translation_buffer (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.xif      (xif.tlb),
		.walk_req (walk_req),
		.walk_vpn (walk_vpn),
		.walk_ack (walk_ack),
		.walk_pfn (walk_pfn)
	);

	assign xif.req     = fetch_req;
	assign xif.vaddr   = fetch_vaddr;
	assign xif.on      = ctrl_q[CTRL_XLATE];
	assign fetch_done  = xif.done;
	assign fetch_paddr = xif.paddr;

	assign slot_cancel = cancel_q;
	assign exc_take    = take_q;
	assign exc_debug   = debug_q;
	assign core_halt   = halt_q;
	assign irq_out     = irq_q;
	assign reg_rdata   = rdata_q;

	// fatal fault first, then the imprecise one, then precise debug and normal interrupts
	always_comb begin
		take_bus = bus_fault_exc && !halt_q;
		take_nmi = nmi_req && !halt_q && !take_bus;
		take_dbg = debug_interrupt_exc && issue_valid && !halt_q && !take_bus && !take_nmi;
		take_irq = irq_req && issue_valid && !halt_q && !take_bus && !take_nmi && !take_dbg;
		any_take = take_bus || take_nmi || take_dbg || take_irq;
		in_slot  = issue_valid && slot_next_q;
		ret_pc   = in_slot ? issue_pc - PC_STEP : issue_pc;
	end

	// slot tracking ignores fetch and refill activity entirely, so a refill
	// that stalls the fetch after the slot cannot disturb what is recorded
	// page-end pair safe
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			slot_next_q <= 1'b0;
			cancel_q    <= 1'b0;
		end else if (any_take || halt_q) begin
			slot_next_q <= 1'b0;
			cancel_q    <= 1'b0;
		end else if (issue_valid) begin
			if (!slot_next_q && dec_has_slot) begin
				slot_next_q <= 1'b1;
				cancel_q    <= dec_likely && !issue_cond_true;
			end else begin
				slot_next_q <= 1'b0;
				cancel_q    <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			last_pc_q <= WORD_RST;
		end else if (issue_valid && !halt_q) begin
			last_pc_q <= issue_pc;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			exception_return_pc_q <= WORD_RST;
			delay_slot_flag_q     <= 1'b0;
			cause_code_q          <= EXC_INT;
		end else if (take_irq) begin
			exception_return_pc_q <= ret_pc;
			delay_slot_flag_q     <= in_slot;
			cause_code_q          <= EXC_INT;
		end else if (take_nmi) begin
			exception_return_pc_q <= last_pc_q;
			delay_slot_flag_q     <= 1'b0;
			cause_code_q          <= EXC_NMI;
		end else if (take_bus) begin
			exception_return_pc_q <= issue_valid ? issue_pc : last_pc_q;
			delay_slot_flag_q     <= 1'b0;
			cause_code_q          <= EXC_BUS;
		end else if (reg_wr && reg_addr == REG_RET_PC) begin
			exception_return_pc_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			debug_return_pc_q       <= WORD_RST;
			debug_delay_slot_flag_q <= 1'b0;
		end else if (take_dbg) begin
			debug_return_pc_q       <= ret_pc;
			debug_delay_slot_flag_q <= in_slot;
		end else if (reg_wr && reg_addr == REG_DPC) begin
			debug_return_pc_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			halt_q  <= 1'b0;
			take_q  <= 1'b0;
			debug_q <= 1'b0;
		end else begin
			halt_q  <= halt_q || take_bus;
			take_q  <= any_take;
			debug_q <= take_dbg;
		end
	end

	// set wins over a write-one clear in the same cycle
	always_comb begin
		evt_set = '0;
		evt_set[EVT_INT] = take_irq;
		evt_set[EVT_DBG] = take_dbg;
		evt_set[EVT_NMI] = take_nmi;
		evt_set[EVT_BUS] = take_bus;
		evt_clr = (reg_wr && reg_addr == REG_EVT) ? reg_wdata[EVT_W-1:0] : '0;
		evt_d   = (evt_q & ~evt_clr) | evt_set;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			evt_q <= '0;
			irq_q <= 1'b0;
		end else begin
			evt_q <= evt_d;
			irq_q <= |(evt_d & mask_q);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mask_q <= '0;
			ctrl_q <= WORD_RST;
		end else if (reg_wr) begin
			if (reg_addr == REG_MASK) begin
				mask_q <= reg_wdata[EVT_W-1:0];
			end
			if (reg_addr == REG_CTRL) begin
				ctrl_q <= {31'h0000_0000, reg_wdata[CTRL_XLATE]};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_q <= WORD_RST;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_RET_PC: rdata_q <= exception_return_pc_q;
				REG_CAUSE: rdata_q <= {delay_slot_flag_q, 24'h00_0000, cause_code_q, 2'h0};
				REG_DPC:   rdata_q <= debug_return_pc_q;
				REG_DEBUG: rdata_q <= {debug_delay_slot_flag_q, 31'h0000_0000};
				REG_EVT:   rdata_q <= {28'h000_0000, evt_q};
				REG_MASK:  rdata_q <= {28'h000_0000, mask_q};
				REG_CTRL:  rdata_q <= ctrl_q;
				REG_ID:    rdata_q <= ID_VALUE;
				default:   rdata_q <= WORD_RST;
			endcase
		end else begin
			rdata_q <= WORD_RST;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	AST_LIKELY_FALSE_CANCELS: assert property ((issue_valid && !slot_next_q && !any_take && !halt_q
		&& dec_likely && !issue_cond_true) |=> slot_cancel)
		else $error("false likely branch did not cancel its slot");
	AST_LIKELY_TRUE_RUNS: assert property ((issue_valid && !slot_next_q && !any_take && !halt_q
		&& dec_likely && issue_cond_true) |=> !slot_cancel)
		else $error("true likely branch cancelled its slot");
	AST_SLOT_BRANCH_PC: assert property ((take_irq && in_slot)
		|=> exc_take && exception_return_pc_q == $past(last_pc_q) && delay_slot_flag_q)
		else $error("slot interrupt did not save branch address and flag");
	AST_SLOT_MINUS_FOUR: assert property ((take_irq && in_slot)
		|=> exception_return_pc_q == $past(issue_pc) - PC_STEP)
		else $error("saved address is not slot minus four");
	AST_DEBUG_SLOT: assert property ((take_dbg && in_slot) |=> exc_debug
		&& debug_return_pc_q == $past(issue_pc) - PC_STEP && debug_delay_slot_flag_q)
		else $error("debug slot entry recorded wrongly");
	AST_PAGE_END_PAIR: assert property ((take_irq && in_slot && cancel_q && issue_pc[PAGE_W-1:0] == 12'hFFC)
		|=> delay_slot_flag_q ##1 !slot_cancel)
		else $error("page-end likely pair lost its slot flag");
	AST_MISS_KEEPS_FLAG: assert property (((take_irq || take_dbg) && in_slot && (walk_req || fetch_req))
		|=> (delay_slot_flag_q || debug_delay_slot_flag_q))
		else $error("fetch miss disturbed slot recording");
	AST_REFILL_NO_EXC: assert property ((walk_req && !irq_req && !debug_interrupt_exc && !nmi_req
		&& !bus_fault_exc) |=> !exc_take)
		else $error("refill raised an exception");
	AST_NMI_IMPRECISE: assert property (take_nmi
		|=> exc_take && exception_return_pc_q == $past(last_pc_q) && !delay_slot_flag_q)
		else $error("nmi entry recorded wrongly");
	AST_BUS_HALTS: assert property (take_bus |=> core_halt [*4])
		else $error("bus fault did not halt the core");
	AST_HALT_QUIET: assert property (core_halt |=> !exc_take && !slot_cancel)
		else $error("halted core still took exceptions");

	COV_CANCEL_SLOT_IRQ: cover property (slot_cancel ##0 take_irq ##1 delay_slot_flag_q);
	COV_TRUE_LIKELY: cover property (issue_valid && dec_likely && issue_cond_true ##1 issue_valid);
	COV_DEBUG_SLOT: cover property (take_dbg && in_slot);
	COV_BUS_FAULT: cover property (take_bus ##1 core_halt);
endmodule // branch_likely_exception_ctl
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: self-checking bench for the branch-likely exception control block
// Assumes: one clk_sys domain; outputs are sampled 1 ns after the edge that updates them
// Notes:   the assertions live in the design files; this bench only drives and compares
`timescale 1ns/1ps
`default_nettype none
module tb
	import blx_pkg::*;
;
	// arbitrary identity value
	localparam logic [31:0] ID_EXP   = 32'h0000_1C3E;
	localparam logic [31:0] NOP      = 32'h0000_0000;
	logic             clk_sys;
	logic             reset;
	logic             issue_valid;
	logic [31:0]      issue_pc;
	logic [31:0]      issue_instr;
	logic             issue_cond_true;
	logic             irq_req;
	logic             debug_interrupt_exc;
	logic             nmi_req;
	logic             bus_fault_exc;
	logic             fetch_req;
	logic [31:0]      fetch_vaddr;
	logic             fetch_done;
	logic [31:0]      fetch_paddr;
	logic             walk_req;
	logic [VPN_W-1:0] walk_vpn;
	logic             walk_ack;
	logic [VPN_W-1:0] walk_pfn;
	logic [7:0]       reg_addr;
	logic [31:0]      reg_wdata;
	logic             reg_wr;
	logic             reg_rd;
	logic [31:0]      reg_rdata;
	logic             slot_cancel;
	logic             exc_take;
	logic             exc_debug;
	logic             core_halt;
	logic             irq_out;
	int               fails;
	int               checks;

	branch_likely_exception_ctl #(.ID_VALUE(ID_EXP), .XLATE_ENTRIES(2)) u_branch_likely_exception_ctl (
		.clk_sys(clk_sys), .reset(reset), .issue_valid(issue_valid), .issue_pc(issue_pc),
		.issue_instr(issue_instr), .issue_cond_true(issue_cond_true), .irq_req(irq_req),
		.debug_interrupt_exc(debug_interrupt_exc), .nmi_req(nmi_req), .bus_fault_exc(bus_fault_exc),
		.fetch_req(fetch_req), .fetch_vaddr(fetch_vaddr), .fetch_done(fetch_done), .fetch_paddr(fetch_paddr),
		.walk_req(walk_req), .walk_vpn(walk_vpn), .walk_ack(walk_ack), .walk_pfn(walk_pfn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.slot_cancel(slot_cancel), .exc_take(exc_take), .exc_debug(exc_debug), .core_halt(core_halt),
		.irq_out(irq_out)
	);

	task automatic wrap_up;
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic do_reset;
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(what, reg_rdata, exp);
	endtask

	task automatic issue(input logic [31:0] pc, input logic [31:0] w, input logic c, input logic i, input logic d);
		@(posedge clk_sys);
		issue_valid         <= 1'b1;
		issue_pc            <= pc;
		issue_instr         <= w;
		issue_cond_true     <= c;
		irq_req             <= i;
		debug_interrupt_exc <= d;
	endtask

	// drops issue_valid and the four exception request lines; the caller then sees that edge's results settled
	task automatic idle;
		@(posedge clk_sys);
		issue_valid         <= 1'b0;
		irq_req             <= 1'b0;
		debug_interrupt_exc <= 1'b0;
		nmi_req             <= 1'b0;
		bus_fault_exc       <= 1'b0;
		#1;
	endtask

	task automatic test_regs;
		logic [7:0]  adr [9] = '{REG_RET_PC, REG_CAUSE, REG_DPC, REG_DEBUG, REG_EVT, REG_MASK, REG_CTRL, REG_ID, 8'h20};
		logic [31:0] aft [9] = '{32'hFFFF_FFFF, 32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h0000_000F, 32'h0000_0001,
			ID_EXP, 32'h0};
		for (int i = 0; i < 9; i++)
			rd_chk("reset value", adr[i], (adr[i] == REG_ID) ? ID_EXP : 32'h0);
		for (int i = 0; i < 9; i++)
			wr(adr[i], 32'hFFFF_FFFF);
		for (int i = 0; i < 9; i++)
			rd_chk("written value", adr[i], aft[i]);
		@(posedge clk_sys);
		#1;
		chk("read data idle", reg_rdata, 32'h0);
		wr(REG_CTRL, 32'h0);
		wr(REG_MASK, 32'h0);
	endtask

	task automatic test_forms;
		logic [31:0] w [11] = '{32'h5000_0000, 32'h5400_0000, 32'h5800_0000, 32'h5C00_0000, 32'h0402_0000,
			32'h0403_0000, 32'h0412_0000, 32'h0413_0000, 32'h4102_0000, 32'h4103_0000, 32'h1000_0000};
		for (int i = 0; i < 11; i++) begin
			for (int c = 0; c < 2; c++) begin
				issue(32'h0000_0100, w[i], c[0], 1'b0, 1'b0);
				issue(32'h0000_0104, NOP, 1'b0, 1'b0, 1'b0);
				#1;
				if (c == 0 && i < 10)
					chk("slot_cancel false", 32'(slot_cancel), 32'h1);
				else
					chk("slot_cancel kept", 32'(slot_cancel), 32'h0);
				idle();
			end
		end
	endtask

	// false likely branch with an interrupt landing on its delay slot
	task automatic slot_exc(input logic [31:0] p, input logic dbg);
		issue(p, 32'h5000_0003, 1'b0, 1'b0, 1'b0);
		issue(p + PC_STEP, NOP, 1'b0, !dbg, dbg);
		#1;
		chk("slot_cancel", 32'(slot_cancel), 32'h1);
		idle();
		chk("exc_take", 32'(exc_take), 32'h1);
		chk("exc_debug", 32'(exc_debug), 32'(dbg));
		chk("slot_cancel flushed", 32'(slot_cancel), 32'h0);
		rd_chk("return pc", dbg ? REG_DPC : REG_RET_PC, p);
		rd_chk("slot flag", dbg ? REG_DEBUG : REG_CAUSE, 32'h8000_0000);
		rd_chk("status", REG_EVT, dbg ? 32'h2 : 32'h1);
		if (!dbg) begin
			chk("irq_out masked", 32'(irq_out), 32'h0);
			wr(REG_MASK, 32'h1);
			// the new mask reaches irq_out one edge after the write lands
			@(posedge clk_sys);
			#1;
			chk("irq_out", 32'(irq_out), 32'h1);
			wr(REG_EVT, 32'h1);
			#1;
			chk("irq_out cleared", 32'(irq_out), 32'h0);
			wr(REG_MASK, 32'h0);
		end else begin
			wr(REG_EVT, 32'hF);
		end
	endtask

	task automatic fetch_chk(input logic [31:0] va, input logic [19:0] pfn, input logic miss);
		logic        seen_walk;
		logic        ack;
		logic        got;
		logic [31:0] pa;
		seen_walk = 1'b0;
		ack       = 1'b0;
		got       = 1'b0;
		pa        = 32'h0;
		@(posedge clk_sys);
		fetch_req   <= 1'b1;
		fetch_vaddr <= va;
		for (int i = 0; i < 20 && !got; i++) begin
			@(posedge clk_sys);
			walk_ack <= ack;
			walk_pfn <= pfn;
			ack = 1'b0;
			#1;
			if (walk_req === 1'b1 && !seen_walk) begin
				seen_walk = 1'b1;
				ack       = 1'b1;
				chk("walk_vpn", 32'(walk_vpn), 32'(va[31:12]));
			end
			if (fetch_done === 1'b1) begin
				got = 1'b1;
				pa  = fetch_paddr;
			end
		end
		@(posedge clk_sys);
		fetch_req <= 1'b0;
		walk_ack  <= 1'b0;
		chk("fetch_done", 32'(got), 32'h1);
		chk("table walk", 32'(seen_walk), 32'(miss));
		chk("fetch_paddr", pa, {pfn, va[11:0]});
	endtask

	// third page evicts the oldest entry; only two pages fit at once
	task automatic test_xlate;
		fetch_chk(32'h0001_2344, 20'h00012, 1'b0);
		wr(REG_CTRL, 32'h1);
		fetch_chk(32'h0001_0010, 20'h0A001, 1'b1);
		fetch_chk(32'h0001_1020, 20'h0A002, 1'b1);
		fetch_chk(32'h0001_0FFC, 20'h0A001, 1'b0);
		fetch_chk(32'h0001_1000, 20'h0A002, 1'b0);
		fetch_chk(32'h0001_2000, 20'h0A003, 1'b1);
		fetch_chk(32'h0001_1004, 20'h0A002, 1'b0);
		fetch_chk(32'h0001_0000, 20'h0A001, 1'b1);
		rd_chk("no miss exception", REG_EVT, 32'h0);
	endtask

	task automatic test_fatal;
		issue(32'h0000_0200, NOP, 1'b0, 1'b0, 1'b0);
		idle();
		@(posedge clk_sys);
		nmi_req <= 1'b1;
		idle();
		chk("nmi taken", 32'(exc_take), 32'h1);
		rd_chk("nmi return pc", REG_RET_PC, 32'h0000_0200);
		rd_chk("nmi cause", REG_CAUSE, 32'(EXC_NMI) << CODE_LO);
		@(posedge clk_sys);
		bus_fault_exc <= 1'b1;
		idle();
		chk("bus fault taken", 32'(exc_take), 32'h1);
		chk("halted", 32'(core_halt), 32'h1);
		rd_chk("bus cause", REG_CAUSE, 32'(EXC_BUS) << CODE_LO);
		issue(32'h0000_0300, NOP, 1'b0, 1'b1, 1'b0);
		idle();
		chk("taken after halt", 32'(exc_take), 32'h0);
		chk("still halted", 32'(core_halt), 32'h1);
		do_reset();
		chk("halt cleared", 32'(core_halt), 32'h0);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// the whole sequence needs a few hundred cycles; this leaves ample margin
	initial begin
		#200000;
		fails++;
		wrap_up();
	end

	initial begin
		fails               = 0;
		checks              = 0;
		reset               = 1'b1;
		issue_valid         = 1'b0;
		issue_pc            = 32'h0;
		issue_instr         = 32'h0;
		issue_cond_true     = 1'b0;
		irq_req             = 1'b0;
		debug_interrupt_exc = 1'b0;
		nmi_req             = 1'b0;
		bus_fault_exc       = 1'b0;
		fetch_req           = 1'b0;
		fetch_vaddr         = 32'h0;
		walk_ack            = 1'b0;
		walk_pfn            = '0;
		reg_addr            = 8'h00;
		reg_wdata           = 32'h0;
		reg_wr              = 1'b0;
		reg_rd              = 1'b0;
		do_reset();
		test_regs();
		test_forms();
		slot_exc(32'h0000_1FF8, 1'b0);
		slot_exc(32'h0000_2FF8, 1'b1);
		test_xlate();
		fork
			slot_exc(32'h0004_0FF8, 1'b0);
			fetch_chk(32'h0004_1000, 20'h0B041, 1'b1);
		join
		test_fatal();
		wrap_up();
	end
endmodule // tb
`default_nettype wire
